/* inc/ddr_read_pkg.sv */
// shared constants for the double-rate single-line read handler
package ddr_read_pkg;

	// instruction codes
	localparam logic [7:0] DDR_SINGLE_READ_CMD       = 8'h0D;
	localparam logic [7:0] DDR_SINGLE_READ_4BYTE_CMD = 8'h0E;

	// last bit index of each phase, counted in captured bits
	localparam logic [5:0] INSTR_LAST   = 6'h07;
	localparam logic [5:0] ADDR_LAST_3B = 6'h17;
	localparam logic [5:0] ADDR_LAST_4B = 6'h1F;
	localparam logic [5:0] MODE_LAST    = 6'h07;

	// training preamble: four clock cycles, one bit per edge
	localparam logic [5:0] PREAMBLE_EDGES = 6'h08;

	// continuous mode is dropped by frames of this many cycles or fewer
	localparam logic [3:0] SHORT_FRAME_CYCLES = 4'h8;

	// dummy clock cycles for each latency code
	localparam logic [4:0] LAT_LC0 = 5'h05;
	localparam logic [4:0] LAT_LC1 = 5'h06;
	localparam logic [4:0] LAT_LC2 = 5'h07;
	localparam logic [4:0] LAT_LC3 = 5'h08;

	// array address width
	localparam int ARRAY_AW_DEF = 24;

	// synchroniser reset level: chip select idle high
	localparam logic [2:0] SYNC_RST = 3'h7;

	// command phases, gray coded along the usual path
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_INSTR = 3'b001,
		ST_ADDR  = 3'b011,
		ST_MODE  = 3'b010,
		ST_DUMMY = 3'b110,
		ST_DATA  = 3'b111,
		ST_SKIP  = 3'b101
	} phase_t;

endpackage

/* hdl/pin_sync.sv */
// two flip-flop synchroniser for asynchronous pins
`timescale 1ns/1ns
module pin_sync #(
	parameter int         W   = 3,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta;

	// first stage is read by the second stage only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta <= RST;
			q    <= RST;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule

/* hdl/edge_find.sv */
// rise and fall detection on synchronised levels
`timescale 1ns/1ns
module edge_find #(
	parameter int           W   = 2,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);

	logic [W-1:0] prev;

	// previous sample for comparison
	always_ff @(posedge clk) begin
		if (!rst_n)
			prev <= RST;
		else
			prev <= level;
	end

	// one-cycle pulses
	assign rise = level & ~prev;
	assign fall = ~level & prev;

endmodule

/* hdl/ddr_single_line_fast_read.sv */
// double-rate single-line fast read handler of the serial flash
//
// Behaviour
// R1: opcode 0Dh with address select clear takes a 3-byte address.
// R2: opcode 0Dh with address select set takes a 4-byte address.
// R3: opcode 0Eh always takes a 4-byte address.
// R4: instruction on rising edges only; address, mode, data on both edges.
// R5: host keeps the serial clock at or below 80 MHz.
// R6: dummy latency length comes from the latency code field.
// R7: no-mode table: instruction, address, latency, no mode cycles.
// R8: input line is ignored during dummy cycles.
// R9: data leaves on the output line one bit per clock edge.
// R10: any start address; counter advances after every byte.
// R11: counter wraps from the top address to zero and keeps going.
// R12: mode table: instruction, address, four mode cycles, latency.
// R13: complementary mode nibbles make the next frame start at address.
// R14: non-complementary mode ends continuous mode at chip-select rise.
// R15: a frame of eight cycles or fewer ends continuous mode.
// R16: host keeps chip select low through mode and dummy cycles.
// R17: a hold or pause never suspends this command.
// R18: training pattern driven on the output line when enabled.
// R19: continuous mode skips the eight-cycle instruction phase.
// R20: training pattern fills the four cycles right before data.
// R21: host releases its drivers for the whole dummy period.
// R22: mode byte arrives msb first; nibbles compared when complete.
// R23: first bits are an instruction, or address in continuous mode.
`timescale 1ns/1ns
module ddr_single_line_fast_read #(
	parameter int ARRAY_AW = ddr_read_pkg::ARRAY_AW_DEF
) (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                cs_n_pin,
	input  wire logic                sclk_pin,
	input  wire logic                si_pin,
	input  wire logic                addr_width_select_bit,
	input  wire logic                latency_table_with_mode,
	input  wire logic [1:0]          latency_code_field,
	input  wire logic                capture_training_pattern,
	input  wire logic [7:0]          training_pattern,
	input  wire logic [7:0]          mem_data,
	output logic                     so,
	output logic                     so_oe,
	output logic      [ARRAY_AW-1:0] mem_addr,
	output logic                     execute_in_place
);

	// dummy edges for a latency code, two edges per clock cycle
	function automatic logic [5:0] lat_edges(input logic [1:0] lc);
		logic [4:0] cyc;
		cyc = ddr_read_pkg::LAT_LC0;
		unique case (lc)
			2'h0: cyc = ddr_read_pkg::LAT_LC0;
			2'h1: cyc = ddr_read_pkg::LAT_LC1;
			2'h2: cyc = ddr_read_pkg::LAT_LC2;
			2'h3: cyc = ddr_read_pkg::LAT_LC3;
		endcase
		return {cyc, 1'b0};
	endfunction

	logic                 cs_n_s;
	logic                 sclk_s;
	logic                 si_s;
	logic [1:0]           rise;
	logic [1:0]           fall;
	logic                 cs_rise;
	logic                 cs_fall;
	logic                 sclk_rise;
	logic                 sclk_edge;
	ddr_read_pkg::phase_t state;
	logic [5:0]           cnt;
	logic [31:0]          sh_in;
	logic [7:0]           sh_out;
	logic                 long_addr;
	logic                 mode_done;
	logic                 mode_ok;
	logic [3:0]           frame_cyc;
	logic [5:0]           dummy_last;
	logic [5:0]           pre_first;
	logic                 pre_allowed;
	logic [7:0]           last_byte;
	logic [31:0]          last_word;
	logic                 instr_end;
	logic                 addr_end;
	logic                 mode_end;
	logic                 dummy_end;
	logic                 data_launch;
	logic                 in_preamble;
	logic                 opcode_ok;
	logic                 opcode_long;

	// all link pins cross into clk through two flops
	pin_sync #(
		.W   (3),
		.RST (ddr_read_pkg::SYNC_RST)
	) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({cs_n_pin, sclk_pin, si_pin}),
		.q     ({cs_n_s, sclk_s, si_s})
	);

	// R17 no hold gating
	// edges of chip select and serial clock; nothing can pause them
	edge_find #(
		.W   (2),
		.RST (ddr_read_pkg::SYNC_RST[2:1])
	) u_edge (
		.clk   (clk),
		.rst_n (rst_n),
		.level ({cs_n_s, sclk_s}),
		.rise  (rise),
		.fall  (fall)
	);

	assign cs_rise   = rise[1];
	assign cs_fall   = fall[1];
	assign sclk_rise = rise[0] & ~cs_n_s;
	// R4 both edges count
	assign sclk_edge = (rise[0] | fall[0]) & ~cs_n_s;

	// assembled values including the bit on the line now
	assign last_byte = {sh_in[6:0], si_s};
	assign last_word = {sh_in[30:0], si_s};

	// R1 short form address
	// R2 select bit widens
	// R3 4-byte opcode
	assign opcode_ok   = (last_byte == ddr_read_pkg::DDR_SINGLE_READ_CMD) ||
		(last_byte == ddr_read_pkg::DDR_SINGLE_READ_4BYTE_CMD);
	assign opcode_long =
		(last_byte == ddr_read_pkg::DDR_SINGLE_READ_4BYTE_CMD) ||
		addr_width_select_bit;

	// R6 latency from code
	assign dummy_last  = lat_edges(latency_code_field) - 6'h01;
	assign pre_allowed = capture_training_pattern &&
		(dummy_last >= ddr_read_pkg::PREAMBLE_EDGES);
	assign pre_first   = dummy_last - ddr_read_pkg::PREAMBLE_EDGES;

	// R4 instruction single rate
	assign instr_end = (state == ddr_read_pkg::ST_INSTR) && sclk_rise &&
		(cnt == ddr_read_pkg::INSTR_LAST);
	assign addr_end  = (state == ddr_read_pkg::ST_ADDR) && sclk_edge &&
		(cnt == (long_addr ? ddr_read_pkg::ADDR_LAST_4B :
		ddr_read_pkg::ADDR_LAST_3B));
	assign mode_end  = (state == ddr_read_pkg::ST_MODE) && sclk_edge &&
		(cnt == ddr_read_pkg::MODE_LAST);
	assign dummy_end = (state == ddr_read_pkg::ST_DUMMY) && sclk_edge &&
		(cnt == dummy_last);

	// the edge closing the dummy period already launches data bit 7
	assign data_launch = dummy_end ||
		((state == ddr_read_pkg::ST_DATA) && sclk_edge);
	// R20 four cycles before data
	assign in_preamble = pre_allowed && (state == ddr_read_pkg::ST_DUMMY) &&
		sclk_edge && (cnt >= pre_first) && (cnt != dummy_last);

	// command phase sequencing
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= ddr_read_pkg::ST_IDLE;
			cnt   <= 6'h00;
		end else if (cs_n_s) begin
			state <= ddr_read_pkg::ST_IDLE;
			cnt   <= 6'h00;
		end else if (cs_fall) begin
			// R23 instruction or address
			// R19 instruction skipped
			state <= execute_in_place ? ddr_read_pkg::ST_ADDR :
				ddr_read_pkg::ST_INSTR;
			cnt   <= 6'h00;
		end else begin
			unique case (state)
				ddr_read_pkg::ST_IDLE, ddr_read_pkg::ST_SKIP: begin
					cnt <= cnt;
				end
				ddr_read_pkg::ST_DATA: begin
					// low three bits give the bit phase of the byte
					if (sclk_edge)
						cnt <= cnt + 6'h01;
				end
				ddr_read_pkg::ST_INSTR: begin
					if (instr_end) begin
						cnt   <= 6'h00;
						// other opcodes belong to other handlers
						state <= opcode_ok ? ddr_read_pkg::ST_ADDR :
							ddr_read_pkg::ST_SKIP;
					end else if (sclk_rise) begin
						cnt <= cnt + 6'h01;
					end
				end
				ddr_read_pkg::ST_ADDR: begin
					if (addr_end) begin
						cnt   <= 6'h00;
						// R12 mode table
						// R7 no mode cycles
						state <= latency_table_with_mode ?
							ddr_read_pkg::ST_MODE : ddr_read_pkg::ST_DUMMY;
					end else if (sclk_edge) begin
						cnt <= cnt + 6'h01;
					end
				end
				ddr_read_pkg::ST_MODE: begin
					if (mode_end) begin
						cnt   <= 6'h00;
						state <= ddr_read_pkg::ST_DUMMY;
					end else if (sclk_edge) begin
						cnt <= cnt + 6'h01;
					end
				end
				ddr_read_pkg::ST_DUMMY: begin
					if (dummy_end) begin
						// bit 7 of the first byte leaves on this edge
						cnt   <= 6'h01;
						state <= ddr_read_pkg::ST_DATA;
					end else if (sclk_edge) begin
						cnt <= cnt + 6'h01;
					end
				end
				default: begin
					state <= ddr_read_pkg::ST_IDLE;
					cnt   <= 6'h00;
				end
			endcase
		end
	end

	// input shift register; cleared so a short address reads high zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sh_in <= 32'h0000_0000;
		end else if (cs_fall || instr_end || addr_end) begin
			sh_in <= 32'h0000_0000;
		end else if ((state == ddr_read_pkg::ST_INSTR && sclk_rise) ||
			((state == ddr_read_pkg::ST_ADDR ||
			state == ddr_read_pkg::ST_MODE) && sclk_edge)) begin
			// R8 dummy input ignored
			// R22 msb first
			sh_in <= last_word;
		end
	end

	// address length follows the last decoded instruction
	always_ff @(posedge clk) begin
		if (!rst_n)
			long_addr <= 1'b0;
		else if (instr_end && opcode_ok)
			long_addr <= opcode_long;
	end

	// mode byte verdict, kept until the next frame starts
	always_ff @(posedge clk) begin
		if (!rst_n || cs_fall) begin
			mode_done <= 1'b0;
			mode_ok   <= 1'b0;
		end else if (mode_end) begin
			// R22 nibbles compared
			mode_done <= 1'b1;
			mode_ok   <= (last_byte[7:4] == ~last_byte[3:0]);
		end
	end

	// clock cycles seen in this frame, saturating above the short limit
	always_ff @(posedge clk) begin
		if (!rst_n || cs_fall)
			frame_cyc <= 4'h0;
		else if (sclk_rise && frame_cyc <= ddr_read_pkg::SHORT_FRAME_CYCLES)
			frame_cyc <= frame_cyc + 4'h1;
	end

	// continuous mode decided at chip-select rise
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			execute_in_place <= 1'b0;
		end else if (cs_rise) begin
			if (execute_in_place &&
				frame_cyc <= ddr_read_pkg::SHORT_FRAME_CYCLES)
				// R15 short frame exit
				execute_in_place <= 1'b0;
			else if (mode_done)
				// R13 complementary stays
				// R14 otherwise leave
				execute_in_place <= mode_ok;
			else
				// a frame cut before the mode byte leaves mode unknown
				execute_in_place <= 1'b0;
		end
	end

	// array address: loaded at address end, stepped per byte sent
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mem_addr <= '0;
		end else if (addr_end) begin
			// R10 any start byte
			mem_addr <= last_word[ARRAY_AW-1:0];
		end else if (data_launch && (state == ddr_read_pkg::ST_DUMMY ||
			cnt[2:0] == 3'h0)) begin
			// R11 wraps to zero
			mem_addr <= mem_addr + ARRAY_AW'(1);
		end
	end

	// byte phase inside the data stream, reusing cnt low bits
	// output line and its enable
	always_ff @(posedge clk) begin
		if (!rst_n || cs_n_s) begin
			so     <= 1'b0;
			so_oe  <= 1'b0;
			sh_out <= 8'h00;
		end else if (data_launch) begin
			// R9 bit per edge
			so_oe <= 1'b1;
			if (state == ddr_read_pkg::ST_DUMMY ||
				cnt[2:0] == 3'h0) begin
				so     <= mem_data[7];
				sh_out <= {mem_data[6:0], 1'b0};
			end else begin
				so     <= sh_out[7];
				sh_out <= {sh_out[6:0], 1'b0};
			end
		end else if (in_preamble) begin
			// R18 training pattern
			so_oe <= 1'b1;
			if (cnt == pre_first) begin
				so     <= training_pattern[7];
				sh_out <= {training_pattern[6:0], 1'b0};
			end else begin
				so     <= sh_out[7];
				sh_out <= {sh_out[6:0], 1'b0};
			end
		end
	end

endmodule

/* bench/fast_read_asserts.sv */
// port checker for the double-rate read handler
`timescale 1ns/1ns
module fast_read_asserts #(
	parameter int ARRAY_AW = 24
) (
	input wire logic                clk,
	input wire logic                rst_n,
	input wire logic                cs_n_pin,
	input wire logic                sclk_pin,
	input wire logic                latency_table_with_mode,
	input wire logic                capture_training_pattern,
	input wire logic [7:0]          training_pattern,
	input wire logic                so,
	input wire logic                so_oe,
	input wire logic [ARRAY_AW-1:0] mem_addr,
	input wire logic                execute_in_place
);
	logic       sclk_q;
	logic [3:0] since;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// cycles since the serial clock pin moved; saturates when idle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclk_q <= 1'b0;
			since  <= 4'hF;
		end else begin
			sclk_q <= sclk_pin;
			if (sclk_q != sclk_pin)
				since <= 4'h0;
			else if (since != 4'hF)
				since <= since + 4'h1;
		end
	end
	a_oe_idle: assert property (cs_n_pin [*6] |-> !so_oe)
		else $error("output enabled while deselected");
	a_so_paced: assert property (so_oe && $past(so_oe) && !$stable(so)
		|-> since <= 4'h6)
		else $error("output moved without a clock edge");
	a_oe_start: assert property ($rose(so_oe) |-> !cs_n_pin
		&& since <= 4'h6)
		else $error("output enable rose out of frame");
	a_preamble_first: assert property ($rose(so_oe)
		&& capture_training_pattern |-> so == training_pattern[7])
		else $error("first driven bit is not pattern msb");
	a_addr_idle: assert property (cs_n_pin [*6] |-> $stable(mem_addr))
		else $error("address moved while deselected");
	a_addr_paced: assert property (!$stable(mem_addr)
		|-> since <= 4'h6)
		else $error("address moved without a clock edge");
	a_xip_entry: assert property ($rose(execute_in_place)
		|-> cs_n_pin && latency_table_with_mode)
		else $error("continuous mode entered wrongly");
	a_xip_exit: assert property ($fell(execute_in_place)
		|-> cs_n_pin)
		else $error("continuous mode left inside a frame");
endmodule
bind ddr_single_line_fast_read fast_read_asserts #(.ARRAY_AW(ARRAY_AW)) chk (
	.clk                     (clk),
	.rst_n                   (rst_n),
	.cs_n_pin                (cs_n_pin),
	.sclk_pin                (sclk_pin),
	.latency_table_with_mode (latency_table_with_mode),
	.capture_training_pattern(capture_training_pattern),
	.training_pattern        (training_pattern),
	.so                      (so),
	.so_oe                   (so_oe),
	.mem_addr                (mem_addr),
	.execute_in_place        (execute_in_place)
);

/* bench/spi_host_model.sv */
// serial host model: chip select, clock and input line
`timescale 1ns/1ns
module spi_host_model (
	output logic      cs_n_pin,
	output logic      sclk_pin,
	output logic      si_pin,
	input  wire logic so,
	input  wire logic so_oe
);
	logic s_so [0:63];
	logic s_oe [0:63];
	initial begin
		cs_n_pin = 1'b1;
		sclk_pin = 1'b0;
		si_pin   = 1'b1;
	end
	// one frame; s_so[d] holds the answer to post edge d-2
	task automatic frame(input logic ins, input logic [7:0] op,
		input logic [31:0] a, input int nab, input logic md_en,
		input logic [7:0] md, input int npost);
		logic q[$];
		int   na;
		for (int i = 0; i < 8 && ins; i++) begin
			q.push_back(op[7-i]);
			if (i < 7)
				q.push_back(op[7-i]);
		end
		for (int i = nab * 8 - 1; i >= 0; i--)
			q.push_back(a[i]);
		for (int i = 7; i >= 0 && md_en; i--)
			q.push_back(md[i]);
		na = q.size();
		cs_n_pin = 1'b0;
		si_pin = (na > 0) ? q[0] : 1'b1;
		#400;
		for (int i = 0; i < na + npost; i++) begin
			sclk_pin = ~sclk_pin;
			#200;
			if (i >= na) begin
				s_so[i-na+1] = so;
				s_oe[i-na+1] = so_oe;
			end
			si_pin = (i + 1 < na) ? q[i+1] : ~si_pin;
			#200;
		end
		if (sclk_pin) begin
			sclk_pin = 1'b0;
			#400;
		end
		cs_n_pin = 1'b1;
		si_pin = ~si_pin;
		#800;
	endtask
endmodule

/* bench/testbench.sv */
// self-checking bench for the double-rate read handler
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
	failures++; $display("Error %s expected %0h seen %0h", n, e, g); end end
module testbench;
	logic       clk;
	logic       rst_n;
	logic       cs_n_pin;
	logic       sclk_pin;
	logic       si_pin;
	logic       addr_width_select_bit;
	logic       latency_table_with_mode;
	logic [1:0] latency_code_field;
	logic       capture_training_pattern;
	logic [7:0] training_pattern;
	logic [7:0] mem_data;
	logic       so;
	logic       so_oe;
	logic [7:0] mem_addr;
	logic       execute_in_place;
	int         failures = 0;
	int         num_checks = 0;
	int         cycles = 0;
	ddr_single_line_fast_read #(.ARRAY_AW(8)) DUT (
		.clk                     (clk),
		.rst_n                   (rst_n),
		.cs_n_pin                (cs_n_pin),
		.sclk_pin                (sclk_pin),
		.si_pin                  (si_pin),
		.addr_width_select_bit   (addr_width_select_bit),
		.latency_table_with_mode (latency_table_with_mode),
		.latency_code_field      (latency_code_field),
		.capture_training_pattern(capture_training_pattern),
		.training_pattern        (training_pattern),
		.mem_data                (mem_data),
		.so                      (so),
		.so_oe                   (so_oe),
		.mem_addr                (mem_addr),
		.execute_in_place        (execute_in_place)
	);
	spi_host_model host (
		.cs_n_pin(cs_n_pin),
		.sclk_pin(sclk_pin),
		.si_pin  (si_pin),
		.so      (so),
		.so_oe   (so_oe)
	);
	// array contents: each byte is its inverted address
	assign mem_data = ~mem_addr;
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// hang guard, well above the few thousand cycles needed
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// one read frame, then preamble and data judged edge by edge
	task automatic rd(input logic [7:0] op, input logic sel, input int nab,
		input logic [1:0] lc, input logic pre, input logic md_en,
		input logic [7:0] md, input logic ins, input logic [31:0] a,
		input int nby);
		int         d;
		logic [7:0] b;
		d = 2 * (int'(ddr_read_pkg::LAT_LC0) + int'(lc));
		addr_width_select_bit = sel;
		latency_table_with_mode = md_en;
		latency_code_field = lc;
		capture_training_pattern = pre;
		host.frame(ins, op, a, nab, md_en, md, d + 8 * nby);
		for (int k = 0; k < 8 && pre; k++)
			`CHK("preamble", training_pattern[7-k], host.s_so[d-7+k])
		for (int j = 0; j < 8 * nby; j++) begin
			b = ~(a[7:0] + 8'(j / 8));
			`CHK("data", b[7-j%8], host.s_so[d+1+j])
			`CHK("enable", 1'b1, host.s_oe[d+1+j])
		end
	endtask
	task automatic t_plain();
		training_pattern = 8'h34;
		rd(8'h0D, 1'b0, 3, 2'h0, 1'b1, 1'b0, 8'h00, 1'b1, 32'h00AB_CDFE, 3);
	endtask
	task automatic t_widths();
		training_pattern = 8'hC9;
		rd(8'h0E, 1'b0, 4, 2'h3, 1'b0, 1'b0, 8'h00, 1'b1, 32'h1234_5607, 1);
		rd(8'h0D, 1'b1, 4, 2'h1, 1'b1, 1'b0, 8'h00, 1'b1, 32'hDEAD_BE10, 1);
		rd(8'h0D, 1'b0, 3, 2'h2, 1'b1, 1'b0, 8'h00, 1'b1, 32'h0000_0081, 1);
	endtask
	task automatic t_xip();
		rd(8'h0D, 1'b0, 3, 2'h0, 1'b0, 1'b1, 8'hA5, 1'b1, 32'h0000_0040, 1);
		`CHK("continuous", 1'b1, execute_in_place)
		rd(8'h00, 1'b0, 3, 2'h1, 1'b0, 1'b1, 8'h33, 1'b0, 32'h0000_0077, 2);
		`CHK("continuous", 1'b0, execute_in_place)
		rd(8'h0D, 1'b0, 3, 2'h0, 1'b1, 1'b1, 8'h00, 1'b1, 32'h0000_0012, 1);
	endtask
	task automatic t_short();
		logic [7:0] codes [3] = '{8'hA5, 8'h5A, 8'h0F};
		foreach (codes[i]) begin
			rd(8'h0E, 1'b0, 4, 2'h0, 1'b0, 1'b1, codes[i], 1'b1, 32'h0000_0033, 1);
			`CHK("continuous", 1'b1, execute_in_place)
			host.frame(1'b0, 8'h00, 32'h0000_0000, 0, 1'b0, 8'h00, 16);
			`CHK("continuous", 1'b0, execute_in_place)
		end
	endtask
	initial begin
		rst_n = 1'b0;
		addr_width_select_bit = 1'b0;
		latency_table_with_mode = 1'b0;
		latency_code_field = 2'h0;
		capture_training_pattern = 1'b0;
		training_pattern = 8'h00;
		repeat (3) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (6) @(posedge clk);
		#1;
		t_plain();
		t_widths();
		t_xip();
		t_short();
		wrap_up();
	end
endmodule
